// File: verilog/udbt_pkg.sv
// Constants and types shared by the Ultra DMA burst sequencer
`default_nettype none
package udbt_pkg;
  // System clock period, ns
  localparam int CLK_NS = 100;
  localparam int PS_PER_NS = 1000;
  localparam int MODES = 5;
  localparam int TW = 4;
  typedef logic [TW-1:0] udbt_cnt_t;
  typedef logic [2:0] udbt_mode_t;
  typedef logic [2:0] udbt_pins_t;
  localparam udbt_mode_t MODE_MAX = 3'h4;

  // Captured host pin vector: {dmack_n, stop, hdmardy_n}
  localparam int PIN_DMACK_N = 2;
  localparam int PIN_STOP = 1;
  localparam int PIN_HRDY_N = 0;
  localparam udbt_pins_t PINS_IDLE = 3'h5;

  localparam udbt_cnt_t CNT_ZERO = 4'h0;
  localparam udbt_cnt_t CNT_ONE = 4'h1;
  localparam udbt_cnt_t CNT_MAX = 4'hF;

  // Interval figures per mode 0..4, and one T_SS_NS shared by all modes
  localparam int T_RP_NS [MODES] = '{160, 125, 100, 100, 100};
  localparam int T_DZFS_PS [MODES] = '{70000, 48000, 31000, 20000, 6700};
  localparam int T_SS_NS = 50;
  // Strobe edge spacing; two clocks keeps every mode above its cycle time
  localparam int T_STB_GAP_NS = 200;

  // Least time, rounded up to whole clocks, never below one
  function automatic udbt_cnt_t cyc_min(input int ps);
    int c;
    c = (ps + CLK_NS * PS_PER_NS - 1) / (CLK_NS * PS_PER_NS);
    if (c < 1) c = 1;
    return udbt_cnt_t'(c);
  endfunction

  localparam udbt_cnt_t RP_CYC [MODES] = '{
    cyc_min(T_RP_NS[0] * PS_PER_NS), cyc_min(T_RP_NS[1] * PS_PER_NS),
    cyc_min(T_RP_NS[2] * PS_PER_NS), cyc_min(T_RP_NS[3] * PS_PER_NS),
    cyc_min(T_RP_NS[4] * PS_PER_NS)};
  localparam udbt_cnt_t DZFS_CYC [MODES] = '{
    cyc_min(T_DZFS_PS[0]), cyc_min(T_DZFS_PS[1]), cyc_min(T_DZFS_PS[2]),
    cyc_min(T_DZFS_PS[3]), cyc_min(T_DZFS_PS[4])};
  localparam udbt_cnt_t SS_CYC = cyc_min(T_SS_NS * PS_PER_NS);
  localparam udbt_cnt_t STB_GAP_CYC = cyc_min(T_STB_GAP_NS * PS_PER_NS);
endpackage
`default_nettype wire

// File: verilog/udbt_link_if.sv
// Captured host pin levels passed from the link domain to the core
`timescale 1ns/1ps
`default_nettype none
interface udbt_link_if;
  udbt_pkg::udbt_pins_t pins;
  modport rx   (output pins);
  modport core (input pins);
endinterface
`default_nettype wire

// File: verilog/udbt_link_rx.sv
// Link-clock capture of the host handshake pins
`timescale 1ns/1ps
`default_nettype none
module udbt_link_rx (
  input  wire logic  link_clk,  // Link-side clock
  input  wire logic  rst,       // Async reset, active high
  input  wire logic  dmack_n,   // Host acknowledge pin
  input  wire logic  stop,      // Host stop pin
  input  wire logic  hdmardy_n, // Host ready pin
  udbt_link_if.rx    lnk        // Captured levels toward the core
);
  import udbt_pkg::*;

  udbt_pins_t meta_ff;
  udbt_pins_t hold_ff;

  // Two stages on the link clock before anything reads the pins
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= PINS_IDLE;
      hold_ff <= PINS_IDLE;
    end else begin
      meta_ff <= {dmack_n, stop, hdmardy_n};
      hold_ff <= meta_ff;
    end
  end

  assign lnk.pins = hold_ff;
endmodule
`default_nettype wire

// File: verilog/udbt_core.sv
// Card-side Ultra DMA burst sequencer with interval counters
`timescale 1ns/1ps
`default_nettype none
module udbt_core (
  input  wire logic                 clk,       // System clock, 10 MHz
  input  wire logic                 rst,       // Async reset, active high
  input  wire logic                 link_clk,  // Clock of the pin capture
  input  wire logic                 dmack_n,   // Host acknowledge pin, low active
  input  wire logic                 stop,      // Host stop pin
  input  wire logic                 hdmardy_n, // Host ready pin, low active
  input  wire logic                 burst_req, // Start a burst
  input  wire logic                 dir_in,    // 1: card sends data
  input  wire udbt_pkg::udbt_mode_t mode,      // Ultra DMA mode 0..4
  input  wire logic                 end_req,   // Card ends the burst
  input  wire logic                 pause_req, // Card pauses a data-out burst
  output logic                      dmarq,     // DMA request pin
  output logic                      iordy_o,   // Strobe or ready_n level
  output logic                      iordy_oe,  // Ready line driven
  output logic                      dd_oe,     // Data bus driven
  output logic                      busy,      // Burst in progress
  output logic                      paused     // Card pause in effect
);
  import udbt_pkg::*;
  typedef enum logic [8:0] {
    S_IDLE   = 9'h001,
    S_REQ    = 9'h002,
    S_FIRST  = 9'h004,
    S_XFER   = 9'h008,
    S_HPAUSE = 9'h010,
    S_OUT    = 9'h020,
    S_RPAUSE = 9'h040,
    S_TERM   = 9'h080,
    S_WACK   = 9'h100
  } udbt_state_t;
  udbt_link_if lnk ();
  udbt_link_rx u_rx (
    .link_clk  (link_clk),
    .rst       (rst),
    .dmack_n   (dmack_n),
    .stop      (stop),
    .hdmardy_n (hdmardy_n),
    .lnk       (lnk)
  );
  udbt_pins_t  cross_ff;
  udbt_pins_t  pins_ff;
  udbt_state_t st_ff,      nxt_st;
  udbt_mode_t  mode_ff,    nxt_mode;
  udbt_cnt_t   tmr_ff,     nxt_tmr;
  udbt_cnt_t   stb_age_ff;
  udbt_cnt_t   oe_age_ff;
  logic        dir_ff,     nxt_dir;
  logic        armed_ff,   nxt_armed;
  logic        dmarq_ff,   nxt_dmarq;
  logic        iordy_o_ff, nxt_iordy_o;
  logic        iordy_oe_ff, nxt_iordy_oe;
  logic        dd_oe_ff,   nxt_dd_oe;
  logic        busy_ff,    nxt_busy;
  logic        paused_ff,  nxt_paused;
  logic        dmack;
  logic        stop_s;
  logic        hrdy;
  logic        host_end;
  logic        tmr_done;
  logic        stb_chg;
  logic        oe_rise;
  // Cross the captured levels; the first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cross_ff <= PINS_IDLE;
      pins_ff  <= PINS_IDLE;
    end else begin
      cross_ff <= lnk.pins;
      pins_ff  <= cross_ff;
    end
  end
  // Pin decode; stop only ends a burst once the host has negated it
  assign dmack    = ~pins_ff[PIN_DMACK_N];
  assign stop_s   = pins_ff[PIN_STOP];
  assign hrdy     = ~pins_ff[PIN_HRDY_N];
  assign host_end = (stop_s & armed_ff) | end_req;
  assign tmr_done = tmr_ff <= CNT_ONE;
  assign stb_chg  = nxt_iordy_o != iordy_o_ff;
  assign oe_rise  = nxt_dd_oe & ~dd_oe_ff;
  // Burst sequencing; the interval timer counts down to zero and reads done at one
  always_comb begin
    nxt_st       = st_ff;
    nxt_mode     = mode_ff;
    nxt_dir      = dir_ff;
    nxt_armed    = armed_ff | (dmack & ~stop_s);
    nxt_dmarq    = dmarq_ff;
    nxt_iordy_o  = iordy_o_ff;
    nxt_iordy_oe = iordy_oe_ff;
    nxt_dd_oe    = dd_oe_ff;
    nxt_busy     = busy_ff;
    nxt_paused   = paused_ff;
    nxt_tmr      = (tmr_ff != CNT_ZERO) ? tmr_ff - CNT_ONE : tmr_ff;
    unique case (st_ff)
      S_IDLE: begin
        nxt_armed = '0;
        if (burst_req) begin
          nxt_dmarq = '1;
          nxt_busy  = '1;
          nxt_dir   = dir_in;
          nxt_mode  = (mode > MODE_MAX) ? MODE_MAX : mode;
          nxt_st    = S_REQ;
        end
      end
      S_REQ: begin
        // Handshake lines are ignored until request and acknowledge meet
        if (dmack) begin
          nxt_iordy_oe = '1;
          if (dir_ff) begin
            nxt_iordy_o = '1;
            nxt_dd_oe   = '1;
            nxt_tmr     = DZFS_CYC[mode_ff];
            nxt_st      = S_FIRST;
          end else begin
            nxt_iordy_o = '0;
            nxt_st      = S_OUT;
          end
        end
      end
      S_FIRST: begin
        // First fall as soon as data has settled, stop is seen low and host ready is asserted
        if (tmr_done && !stop_s && hrdy) begin
          nxt_iordy_o = '0;
          nxt_tmr     = STB_GAP_CYC;
          nxt_st      = S_XFER;
        end
      end
      S_XFER: begin
        if (host_end) begin
          nxt_tmr = SS_CYC;
          nxt_st  = S_TERM;
        end else if (!hrdy) begin
          nxt_st = S_HPAUSE;
        end else if (tmr_done) begin
          nxt_iordy_o = ~iordy_o_ff;
          nxt_tmr     = STB_GAP_CYC;
        end
      end
      S_HPAUSE: begin
        if (host_end) begin
          nxt_tmr = SS_CYC;
          nxt_st  = S_TERM;
        end else if (hrdy) begin
          nxt_st = S_XFER;
        end
      end
      S_OUT: begin
        if (host_end) begin
          nxt_tmr = SS_CYC;
          nxt_st  = S_TERM;
        end else if (pause_req) begin
          nxt_iordy_o = '1;
          nxt_tmr     = RP_CYC[mode_ff];
          nxt_st      = S_RPAUSE;
        end
      end
      S_RPAUSE: begin
        if (host_end) begin
          nxt_tmr = SS_CYC;
          nxt_st  = S_TERM;
        end else if (!pause_req) begin
          nxt_iordy_o = '0;
          nxt_paused  = '0;
          nxt_st      = S_OUT;
        end else if (tmr_done) begin
          nxt_paused = '1;
        end
      end
      S_TERM: begin
        nxt_paused = '0;
        if (tmr_done) begin
          nxt_dmarq = '0;
          nxt_st    = S_WACK;
        end
      end
      S_WACK: begin
        // Drop both drivers on the edge after acknowledge goes away
        if (!dmack) begin
          nxt_iordy_oe = '0;
          nxt_dd_oe    = '0;
          nxt_busy     = '0;
          nxt_st       = S_IDLE;
        end
      end
    endcase
  end

  // State and pin registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff       <= S_IDLE;
      mode_ff     <= MODE_MAX;
      tmr_ff      <= CNT_ZERO;
      dir_ff      <= '0;
      armed_ff    <= '0;
      dmarq_ff    <= '0;
      iordy_o_ff  <= '1;
      iordy_oe_ff <= '0;
      dd_oe_ff    <= '0;
      busy_ff     <= '0;
      paused_ff   <= '0;
    end else begin
      st_ff       <= nxt_st;
      mode_ff     <= nxt_mode;
      tmr_ff      <= nxt_tmr;
      dir_ff      <= nxt_dir;
      armed_ff    <= nxt_armed;
      dmarq_ff    <= nxt_dmarq;
      iordy_o_ff  <= nxt_iordy_o;
      iordy_oe_ff <= nxt_iordy_oe;
      dd_oe_ff    <= nxt_dd_oe;
      busy_ff     <= nxt_busy;
      paused_ff   <= nxt_paused;
    end
  end

  // Ages since the last ready-line change and since data drive began
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stb_age_ff <= CNT_MAX;
      oe_age_ff  <= CNT_MAX;
    end else begin
      stb_age_ff <= stb_chg ? CNT_ZERO :
                    (stb_age_ff == CNT_MAX) ? stb_age_ff : stb_age_ff + CNT_ONE;
      oe_age_ff  <= oe_rise ? CNT_ZERO :
                    (oe_age_ff == CNT_MAX) ? oe_age_ff : oe_age_ff + CNT_ONE;
    end
  end

  assign dmarq    = dmarq_ff;
  assign iordy_o  = iordy_o_ff;
  assign iordy_oe = iordy_oe_ff;
  assign dd_oe    = dd_oe_ff;
  assign busy     = busy_ff;
  assign paused   = paused_ff;

  // Checks on the sequencer, all in the system clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take;
    st_ff == S_REQ && dmack;
  endsequence
  sequence s_first_edge;
    st_ff == S_FIRST ##1 st_ff == S_XFER;
  endsequence
  sequence s_release;
    st_ff == S_WACK && !dmack;
  endsequence
  a_rfs_no_edge: assert property (
    (dir_ff && iordy_oe_ff && !hrdy) |=> $stable(iordy_o_ff))
    else $error("strobe edge after host ready dropped");
  a_rp_min_wait: assert property (
    $rose(paused_ff) |-> stb_age_ff >= RP_CYC[mode_ff])
    else $error("pause taken before ready-to-pause time");
  a_ss_before_end: assert property (
    ($fell(dmarq_ff) && dir_ff) |-> stb_age_ff >= SS_CYC)
    else $error("request dropped too soon after last strobe");
  a_first_strobe: assert property (
    (st_ff == S_FIRST && !stop_s && hrdy) |=> (!iordy_o_ff && st_ff == S_XFER))
    else $error("first strobe fall late");
  a_data_release: assert property (
    s_release |=> !dd_oe_ff)
    else $error("data drivers not released");
  a_iordy_release: assert property (
    s_release |=> !iordy_oe_ff)
    else $error("ready line not released");
  a_iordy_take: assert property (
    s_take |=> iordy_oe_ff)
    else $error("ready line not taken on acknowledge");
  a_dzfs_wait: assert property (
    s_first_edge |-> oe_age_ff >= DZFS_CYC[mode_ff])
    else $error("first strobe too soon after data drive");
  a_no_early_drive: assert property (
    ((st_ff == S_IDLE || st_ff == S_REQ) && !(dmarq_ff && dmack))
      |=> (!iordy_oe_ff && !dd_oe_ff))
    else $error("lines driven before request and acknowledge");
  a_pause_count: assert property (
    $rose(paused_ff) |-> stb_age_ff == RP_CYC[mode_ff])
    else $error("pause counter off its rounded count");
endmodule
`default_nettype wire

// File: sim/udbt_host_model.sv
// Behavioural host side of the Ultra DMA handshake
`timescale 1ns/1ps
`default_nettype none
module udbt_host_model (
  input  wire logic dmarq,      // Card request
  input  wire logic dir_in,     // 1: card sends data
  input  wire logic host_pause, // Bench asks the host to pause
  input  wire logic host_stop,  // Bench asks the host to end
  output logic      dmack_n,    // Acknowledge pin
  output logic      stop,       // Stop pin
  output logic      hdmardy_n   // Host ready pin
);
  initial begin
    dmack_n = 1'b1;
    stop = 1'b0;
    hdmardy_n = 1'b1;
  end

  // One burst per request; the pins only take burst meaning once acknowledged
  always begin
    wait (dmarq === 1'b1);
    #150 stop = 1'b1;
    #20 dmack_n = 1'b0;
    #30 stop = 1'b0;
    hdmardy_n = ~dir_in;
    // Host ready follows the pause wish, never faster than the interlock
    while (dmarq === 1'b1 && host_stop !== 1'b1) begin
      @(host_pause or dmarq or host_stop);
      #20 if (dir_in) hdmardy_n = host_pause;
    end
    if (host_stop === 1'b1) #20 stop = 1'b1;
    wait (dmarq === 1'b0);
    #20 dmack_n = 1'b1;
    stop = 1'b0;
    hdmardy_n = 1'b1;
  end
endmodule
`default_nettype wire

// File: sim/udbt_core_tb.sv
// Self-checking bench for the Ultra DMA burst sequencer
`timescale 1ns/1ps
`default_nettype none
module udbt_core_tb;
  import udbt_pkg::*;
  logic       clk, rst, link_clk, burst_req, dir_in, end_req, pause_req;
  logic       host_pause, host_stop, dmack_n, stop, hdmardy_n;
  logic       dmarq, iordy_o, iordy_oe, dd_oe, busy, paused;
  udbt_mode_t mode;
  udbt_mode_t plan [$];
  int         n_errors, checks_done, cyc;
  int         rp_ns [MODES] = '{160, 125, 100, 100, 100}; // Ready-to-pause least times

  udbt_core dut (.clk(clk), .rst(rst), .link_clk(link_clk), .dmack_n(dmack_n),
    .stop(stop), .hdmardy_n(hdmardy_n), .burst_req(burst_req), .dir_in(dir_in),
    .mode(mode), .end_req(end_req), .pause_req(pause_req), .dmarq(dmarq),
    .iordy_o(iordy_o), .iordy_oe(iordy_oe), .dd_oe(dd_oe), .busy(busy), .paused(paused));
  udbt_host_model host (.dmarq(dmarq), .dir_in(dir_in), .host_pause(host_pause),
    .host_stop(host_stop), .dmack_n(dmack_n), .stop(stop), .hdmardy_n(hdmardy_n));

  // Two unrelated clocks: system 100 ns, link 64 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  // Hang guard; a full run needs well under half of this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait on an output, sampled at falling edges where it is settled
  task automatic wait_sig(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 60) begin
      @(negedge clk);
      n++;
    end
    check(s, v);
  endtask

  // Counts clocks until the strobe level changes
  task automatic edge_gap(output int n);
    logic prev;
    prev = iordy_o;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (iordy_o === prev && n < 10);
  endtask

  task automatic burst(input int id, input logic din, input udbt_mode_t m);
    int   n, gap;
    logic lvl;
    @(negedge clk);
    dir_in = din;
    mode = m;
    burst_req = 1'b1;
    @(negedge clk);
    burst_req = 1'b0;
    check(dmarq, 1'b1);
    check(busy, 1'b1);
    wait_sig(iordy_oe, 1'b1, n);
    check(iordy_o, din);
    check(dd_oe, din);
    if (din) begin
      wait_sig(iordy_o, 1'b0, n);
      check(32'(n <= 8), 1);
      for (int k = 0; k < 4; k++) begin
        edge_gap(n);
        check(n, 2);
      end
      host_pause = 1'b1;
      repeat (9) @(negedge clk);
      lvl = iordy_o;
      repeat (6) @(negedge clk);
      check(iordy_o, lvl);
      host_pause = 1'b0;
      repeat (10) @(negedge clk);
    end else begin
      repeat ($urandom_range(6, 1)) @(negedge clk);
      pause_req = 1'b1;
      @(negedge clk);
      check(iordy_o, 1'b1);
      wait_sig(paused, 1'b1, n);
      // Modes above the top one behave as the top mode
      check(n, (rp_ns[(m > MODE_MAX) ? MODE_MAX : m] + CLK_NS - 1) / CLK_NS);
      pause_req = 1'b0;
      @(negedge clk);
      check(iordy_o, 1'b0);
      check(paused, 1'b0);
    end
    if ($urandom_range(1, 0) == 1) end_req = 1'b1;
    else host_stop = 1'b1;
    gap = 0;
    lvl = iordy_o;
    for (n = 0; dmarq === 1'b1 && n < 60; n++) begin
      @(negedge clk);
      gap = (iordy_o !== lvl) ? 0 : gap + 1;
      lvl = iordy_o;
    end
    check(dmarq, 1'b0);
    check(32'(gap >= 1), 1);
    wait_sig(iordy_oe, 1'b0, n);
    check(32'(n <= 8), 1);
    check(dd_oe, 1'b0);
    check(busy, 1'b0);
    end_req = 1'b0;
    host_stop = 1'b0;
    $display("test %0d done, mode %0d, data-in %0d, errors %0d", id, m, din, n_errors);
  endtask

  initial begin
    rst = 1'b1;
    burst_req = 1'b0;
    dir_in = 1'b0;
    end_req = 1'b0;
    pause_req = 1'b0;
    host_pause = 1'b0;
    host_stop = 1'b0;
    mode = 3'h0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(dmarq, 1'b0);
    check(iordy_o, 1'b1);
    check(iordy_oe, 1'b0);
    check(dd_oe, 1'b0);
    check(paused, 1'b0);
    void'($urandom(44356));
    // Every mode in both directions
    for (int i = 0; i < 10; i++) plan.push_back(udbt_mode_t'(i % MODES));
    // One data-out burst with an out-of-range mode, clamped by the design
    plan.push_back(udbt_mode_t'($urandom_range(7, 5)));
    foreach (plan[i]) burst(i, i < MODES, plan[i]);
    print_verdict();
  end
endmodule
`default_nettype wire
